// >>> hdl/slot_cfg.sv
// Purpose: per-slot optical measurement configuration and decode
// Assumes: register port is synchronous to core_clk_i
// Notes:   settling delays are given as core clock counts
//
// Summary of operation
// - burst average code n selects 2**n pulses, 1 at code 0 to 128 at 7.
// - burst averaging applies only with center-difference ambient method.
// - cubic decimation is used only when enabled and tint code is 3.
// - ambient select 0 is center, 1 is forward difference, ignoring average.
// - led range code sets full scale 32 mA per step up to 128 mA.
// - each channel adc range code doubles full scale from 4 uA to 32 uA.
// - pd settle code sets dark to exposure spacing, 8.1 us to 80.1 us.
// - equal settle codes give pd settling 0.1 us over led settling.
// - led settle code sets delay 8, 12, 16 or 24 us.
// - offset code injects 4 uA per step only during exposure.
// - integration time code selects adc time, 117.1 us at code 3 cubic.
// - led a code zero disables driver a, else scales with led range.
`timescale 1ns/10ps
module slot_cfg
   import slot_cfg_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // register port
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output      logic [7:0]  reg_rdata_o,
   output      logic        reg_hit_o,
   // sequencer
   input  wire logic [2:0]  active_slot_i,
   input  wire logic        exposure_i,
   output      logic [7:0]  burst_pulses_o,
   output      logic [2:0]  burst_average_code_o,
   output      logic        center_difference_method_o,
   output      logic        forward_difference_method_o,
   output      logic        cubic_decimation_o,
   output      logic [1:0]  integration_time_code_o,
   output      logic [1:0]  led_current_range_o,
   output      logic [7:0]  led_full_scale_ma_o,
   output      logic [1:0]  ch1_adc_range_o,
   output      logic [1:0]  ch2_adc_range_o,
   output      logic [5:0]  ch1_full_scale_ua_o,
   output      logic [5:0]  ch2_full_scale_ua_o,
   output      logic [11:0] pd_settle_cycles_o,
   output      logic [11:0] led_settle_cycles_o,
   output      logic [4:0]  ch1_offset_ua_o,
   output      logic [4:0]  ch2_offset_ua_o,
   output      logic        led_driver_a_en_o,
   output      logic [7:0]  led_a_current_code_o
);

   // ****************************************
   // helpers
   // ****************************************
   localparam int DUS_NS = 100;

   // 0.1 us units to clock cycles, rounded down, never below one
   function automatic logic [11:0] dus_to_cyc(input int dus);
      int c;
      c = (dus * DUS_NS) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[11:0];
   endfunction : dus_to_cyc

   // map address to slot index and register kind, kind 7 means miss
   function automatic logic [5:0] decode(input logic [7:0] a);
      logic [5:0] r;
      r = {3'h0, 3'h7};
      for (int s = 0; s < NUM_SLOTS; s++) begin
         for (int k = 0; k < 5; k++) begin
            if (a == 8'(SLOT1_CFG1_ADDR + s * SLOT_STRIDE + k)) begin
               r = {3'(s), 3'(k)};
            end
         end
      end
      return r;
   endfunction : decode

   // ****************************************
   // reset synchroniser
   // ****************************************
   logic rst_s1_reg;
   logic rst_s2_reg;
   logic rst_s1_next;
   logic rst_s2_next;
   // asserts at once, releases two edges later to settle metastability
   always_comb begin
      rst_s1_next = 1'b1;
      rst_s2_next = rst_s1_reg;
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= rst_s1_next;
         rst_s2_reg <= rst_s2_next;
      end
   end
   logic rst_n;
   assign rst_n = rst_s2_reg;

   // ****************************************
   // slot register file
   // ****************************************
   logic [7:0] cfg1_reg [NUM_SLOTS];
   logic [7:0] filt_reg [NUM_SLOTS];
   logic [7:0] setl_reg [NUM_SLOTS];
   logic [7:0] offs_reg [NUM_SLOTS];
   logic [7:0] leda_reg [NUM_SLOTS];
   logic [5:0] wdec;
   logic [5:0] rdec;
   assign wdec = decode(reg_addr_i);
   assign rdec = decode(reg_addr_i);

   // one register set per slot; reserved bits are cleared on write
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
         logic [7:0] cfg1_next;
         logic [7:0] filt_next;
         logic [7:0] setl_next;
         logic [7:0] offs_next;
         logic [7:0] leda_next;
         logic       sel;
         always_comb begin
            sel       = reg_wr_i && (wdec[5:3] == 3'(g));
            cfg1_next = cfg1_reg[g];
            filt_next = filt_reg[g];
            setl_next = setl_reg[g];
            offs_next = offs_reg[g];
            leda_next = leda_reg[g];
            if (sel) begin
               case (wdec[2:0])
                  3'h0: cfg1_next = reg_wdata_i & CFG1_MASK;
                  3'h1: filt_next = reg_wdata_i;
                  3'h2: setl_next = reg_wdata_i & SETL_MASK;
                  3'h3: offs_next = reg_wdata_i & OFFS_MASK;
                  3'h4: leda_next = reg_wdata_i;
                  default: ;
               endcase
            end
         end
         always_ff @(posedge core_clk_i or negedge rst_n) begin
            if (!rst_n) begin
               cfg1_reg[g] <= CFG1_RST;
               filt_reg[g] <= FILT_RST;
               setl_reg[g] <= SETL_RST;
               offs_reg[g] <= OFFS_RST;
               leda_reg[g] <= LEDA_RST;
            end else begin
               cfg1_reg[g] <= cfg1_next;
               filt_reg[g] <= filt_next;
               setl_reg[g] <= setl_next;
               offs_reg[g] <= offs_next;
               leda_reg[g] <= leda_next;
            end
         end
      end
   endgenerate

   // ****************************************
   // read path
   // ****************************************
   // read data stands for one cycle after the strobe, zero otherwise
   logic [7:0] rdata_next;
   logic [7:0] rdata_reg;
   logic       hit_next;
   logic       hit_reg;
   always_comb begin
      rdata_next = 8'h00;
      hit_next   = 1'b0;
      if (reg_rd_i && rdec[2:0] != 3'h7) begin
         hit_next = 1'b1;
         case (rdec[2:0])
            3'h0: rdata_next = cfg1_reg[rdec[5:3]];
            3'h1: rdata_next = filt_reg[rdec[5:3]];
            3'h2: rdata_next = setl_reg[rdec[5:3]];
            3'h3: rdata_next = offs_reg[rdec[5:3]];
            3'h4: rdata_next = leda_reg[rdec[5:3]];
            default: rdata_next = 8'h00;
         endcase
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
         hit_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         hit_reg   <= hit_next;
      end
   end
   assign reg_rdata_o = rdata_reg;
   assign reg_hit_o   = hit_reg;

   // ****************************************
   // active slot decode
   // ****************************************
   typedef struct packed {
      logic [7:0]  pulses;
      logic [2:0]  aver;
      logic        center_difference_method;
      logic        forward_difference_method;
      logic        cubic;
      logic [1:0]  tint;
      logic [1:0]  ledrge;
      logic [7:0]  led_fs;
      logic [1:0]  r1;
      logic [1:0]  r2;
      logic [5:0]  fs1;
      logic [5:0]  fs2;
      logic [11:0] pd_cyc;
      logic [11:0] led_cyc;
      logic [4:0]  off1;
      logic [4:0]  off2;
      logic        leda_en;
      logic [7:0]  leda;
   } act_t;

   act_t       act_next;
   act_t       act_reg;
   logic [2:0] s;
   logic [7:0] c1;
   logic [7:0] f;
   logic [7:0] st;
   logic [7:0] o;
   always_comb begin
      // slot codes 6 and 7 do not exist and fall back to slot 1
      s  = (active_slot_i < 3'(NUM_SLOTS)) ? active_slot_i : 3'h0;
      c1 = cfg1_reg[s];
      f  = filt_reg[s];
      st = setl_reg[s];
      o  = offs_reg[s];
      act_next.center_difference_method   = ~f[FILT_BIT];
      act_next.forward_difference_method   = f[FILT_BIT];
      act_next.aver  = c1[AVER_LSB +: 3];
      act_next.tint  = c1[TINT_LSB +: 2];
      // forward difference ignores the average code
      act_next.pulses = f[FILT_BIT] ? 8'h01
                        : 8'(9'h001 << c1[AVER_LSB +: 3]);
      act_next.cubic = f[SINC3_BIT]
                       && (c1[TINT_LSB +: 2] == TINT_CUBIC);
      act_next.ledrge = f[LEDRGE_LSB +: 2];
      // full scale rises by 32 mA per range step
      act_next.led_fs = 8'(({6'h00, f[LEDRGE_LSB +: 2]} + 8'h01)
                        << 5);
      act_next.r1  = f[CH1RGE_LSB +: 2];
      act_next.r2  = f[CH2RGE_LSB +: 2];
      act_next.fs1 = 6'(6'h04 << f[CH1RGE_LSB +: 2]);
      act_next.fs2 = 6'(6'h04 << f[CH2RGE_LSB +: 2]);
      // settle counts are rounded down to whole core clocks
      act_next.pd_cyc  = dus_to_cyc(PD_SET_DUS[st[PDSET_LSB +: 3]]);
      act_next.led_cyc = dus_to_cyc(LED_SET_DUS[st[LEDSET_LSB +: 2]]);
      // offset current flows only while the exposure window is open
      act_next.off1 = exposure_i ? 5'({o[OFF1_LSB +: 3], 2'b00})
                      : 5'h00;
      act_next.off2 = exposure_i ? 5'({o[OFF2_LSB +: 3], 2'b00})
                      : 5'h00;
      // a zero drive code switches driver a off for the slot
      act_next.leda    = leda_reg[s];
      act_next.leda_en = (leda_reg[s] != 8'h00);
   end
   // all decoded outputs come from one registered snapshot of the slot
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         act_reg <= '0;
      end else begin
         act_reg <= act_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign burst_pulses_o              = act_reg.pulses;
   assign burst_average_code_o        = act_reg.aver;
   assign center_difference_method_o  = act_reg.center_difference_method;
   assign forward_difference_method_o = act_reg.forward_difference_method;
   assign cubic_decimation_o          = act_reg.cubic;
   assign integration_time_code_o     = act_reg.tint;
   assign led_current_range_o         = act_reg.ledrge;
   assign led_full_scale_ma_o         = act_reg.led_fs;
   assign ch1_adc_range_o             = act_reg.r1;
   assign ch2_adc_range_o             = act_reg.r2;
   assign ch1_full_scale_ua_o         = act_reg.fs1;
   assign ch2_full_scale_ua_o         = act_reg.fs2;
   assign pd_settle_cycles_o          = act_reg.pd_cyc;
   assign led_settle_cycles_o         = act_reg.led_cyc;
   assign ch1_offset_ua_o             = act_reg.off1;
   assign ch2_offset_ua_o             = act_reg.off2;
   assign led_driver_a_en_o           = act_reg.leda_en;
   assign led_a_current_code_o        = act_reg.leda;
endmodule : slot_cfg

// >>> hdl/slot_cfg_pkg.sv
// Purpose: constants for the measurement slot configuration block
// Assumes: 8-bit register port, six slots spaced eight addresses apart
// Notes:   offsets are byte register addresses of the slot-1 copy
package slot_cfg_pkg;
   // ****************************************
   // geometry
   // ****************************************
   localparam int          NUM_SLOTS        = 6;
   localparam logic [7:0]  SLOT_STRIDE      = 8'h08;
   localparam logic [7:0]  SLOT1_CFG1_ADDR  = 8'h21;
   localparam logic [7:0]  SLOT1_FILT_ADDR  = 8'h22;
   localparam logic [7:0]  SLOT1_SETL_ADDR  = 8'h23;
   localparam logic [7:0]  SLOT1_OFFS_ADDR  = 8'h24;
   localparam logic [7:0]  SLOT1_LEDA_ADDR  = 8'h25;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0]  CFG1_RST = 8'h18;
   localparam logic [7:0]  FILT_RST = 8'h3A;
   localparam logic [7:0]  SETL_RST = 8'h28;
   localparam logic [7:0]  OFFS_RST = 8'h00;
   localparam logic [7:0]  LEDA_RST = 8'h00;

   // ****************************************
   // field positions and masks
   // ****************************************
   localparam int          AVER_LSB   = 0;
   localparam int          TINT_LSB   = 3;
   localparam int          CH1RGE_LSB = 0;
   localparam int          CH2RGE_LSB = 2;
   localparam int          LEDRGE_LSB = 4;
   localparam int          FILT_BIT   = 6;
   localparam int          SINC3_BIT  = 7;
   localparam int          LEDSET_LSB = 3;
   localparam int          PDSET_LSB  = 5;
   localparam int          OFF1_LSB   = 0;
   localparam int          OFF2_LSB   = 4;
   localparam logic [7:0]  CFG1_MASK  = 8'hDF;
   localparam logic [7:0]  SETL_MASK  = 8'hF8;
   localparam logic [7:0]  OFFS_MASK  = 8'h77;
   localparam logic [1:0]  TINT_CUBIC = 2'h3;

   // ****************************************
   // timing, in units of 0.1 us, and clock
   // ****************************************
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          PD_EXTRA_DUS  = 1;
   localparam int          LED_SET_DUS [4] = '{80, 120, 160, 240};
   localparam int          PD_SET_DUS  [8] =
      '{81, 121, 161, 241, 321, 481, 641, 801};
endpackage : slot_cfg_pkg

// >>> tb/slot_cfg_chk.sv
// Purpose: port checks for the slot configuration block
// Assumes: decoded outputs all come from one register state
// Notes:   decode checks other than AST_CUBIC_OFF start five edges after reset release
`timescale 1ns/10ps
module slot_cfg_chk
   import slot_cfg_pkg::*;
(
   // clock, reset and register port
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_hit_o,
   // sequencer side
   input wire logic [2:0] active_slot_i,
   input wire logic       exposure_i,
   input wire logic [7:0] burst_pulses_o,
   input wire logic [2:0] burst_average_code_o,
   input wire logic       center_difference_method_o,
   input wire logic       forward_difference_method_o,
   input wire logic       cubic_decimation_o,
   input wire logic [1:0] integration_time_code_o,
   input wire logic [1:0] led_current_range_o,
   input wire logic [7:0] led_full_scale_ma_o,
   input wire logic [1:0] ch1_adc_range_o,
   input wire logic [5:0] ch1_full_scale_ua_o,
   input wire logic [4:0] ch1_offset_ua_o,
   input wire logic [4:0] ch2_offset_ua_o,
   input wire logic       led_driver_a_en_o,
   input wire logic [7:0] led_a_current_code_o
);
   logic [2:0] age_reg;
   logic [2:0] age_next;
   logic       live;

   always_comb begin
      age_next = (age_reg == 3'h5) ? age_reg : age_reg + 3'h1;
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         age_reg <= 3'h0;
      end else begin
         age_reg <= age_next;
      end
   end
   assign live = (age_reg == 3'h5);

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence rd_mapped;
      live && reg_rd_i && reg_addr_i >= SLOT1_CFG1_ADDR
         && reg_addr_i <= SLOT1_LEDA_ADDR;
   endsequence
   sequence filt_wr_off;
      reg_wr_i && reg_addr_i == SLOT1_FILT_ADDR && !reg_wdata_i[SINC3_BIT]
         && active_slot_i == 3'h0 ##1 active_slot_i == 3'h0;
   endsequence

   AST_BURST_CENTER: assert property (
      live && center_difference_method_o |->
         burst_pulses_o == (8'h01 << burst_average_code_o))
      else $error("burst count wrong in center mode");
   AST_BURST_FORWARD: assert property (
      live && forward_difference_method_o |-> burst_pulses_o == 8'h01
         && !center_difference_method_o)
      else $error("average not ignored in forward mode");
   AST_CUBIC_TINT: assert property (
      live && cubic_decimation_o |-> integration_time_code_o == TINT_CUBIC)
      else $error("cubic filter used with wrong tint");
   AST_CUBIC_OFF: assert property (filt_wr_off |=> !cubic_decimation_o)
      else $error("cubic filter still used after disable");
   AST_LED_SCALE: assert property (
      live |-> led_full_scale_ma_o == 32 * (led_current_range_o + 1))
      else $error("led full scale wrong");
   AST_ADC_SCALE: assert property (
      live |-> ch1_full_scale_ua_o == (6'h04 << ch1_adc_range_o))
      else $error("adc full scale wrong");
   AST_OFFSET_DARK: assert property (
      live && !$past(exposure_i) |->
         ch1_offset_ua_o == 5'h00 && ch2_offset_ua_o == 5'h00)
      else $error("offset injected outside exposure");
   AST_LEDA_EN: assert property (
      live |-> led_driver_a_en_o == (led_a_current_code_o != 8'h00))
      else $error("driver a enable wrong");
   AST_READ_HIT: assert property (rd_mapped |=> reg_hit_o)
      else $error("mapped read not answered");
endmodule : slot_cfg_chk

bind slot_cfg slot_cfg_chk chk_u (.core_clk_i, .rst_n_i, .reg_wr_i,
   .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_hit_o, .active_slot_i,
   .exposure_i, .burst_pulses_o, .burst_average_code_o,
   .center_difference_method_o, .forward_difference_method_o,
   .cubic_decimation_o, .integration_time_code_o, .led_current_range_o,
   .led_full_scale_ma_o, .ch1_adc_range_o, .ch1_full_scale_ua_o,
   .ch1_offset_ua_o, .ch2_offset_ua_o, .led_driver_a_en_o,
   .led_a_current_code_o);

// >>> tb/tb.sv
// Purpose: register level test of the slot configuration block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   decode checked two edges after each write strobe
`timescale 1ns/10ps
module tb
   import slot_cfg_pkg::*;
;
   logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, exposure_i, reg_hit_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, burst_pulses_o;
   logic [7:0] led_full_scale_ma_o, led_a_current_code_o;
   logic [2:0] active_slot_i, burst_average_code_o;
   logic center_difference_method_o, forward_difference_method_o;
   logic cubic_decimation_o, led_driver_a_en_o;
   logic [1:0] integration_time_code_o, led_current_range_o;
   logic [1:0] ch1_adc_range_o, ch2_adc_range_o;
   logic [5:0] ch1_full_scale_ua_o, ch2_full_scale_ua_o;
   logic [11:0] pd_settle_cycles_o, led_settle_cycles_o;
   logic [4:0] ch1_offset_ua_o, ch2_offset_ua_o;
   logic [11:0] pd_tab [8] = '{12'h0A2, 12'h0F2, 12'h142, 12'h1E2,
                               12'h282, 12'h3C2, 12'h502, 12'h642};
   logic [11:0] led_tab [4] = '{12'h0A0, 12'h0F0, 12'h140, 12'h1E0};
   int compares, n_mismatch, cycles;

   slot_cfg dut_u (.core_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
      .reg_wdata_i, .reg_rdata_o, .reg_hit_o, .active_slot_i, .exposure_i,
      .burst_pulses_o, .burst_average_code_o, .center_difference_method_o,
      .forward_difference_method_o, .cubic_decimation_o,
      .integration_time_code_o, .led_current_range_o, .led_full_scale_ma_o,
      .ch1_adc_range_o, .ch2_adc_range_o, .ch1_full_scale_ua_o,
      .ch2_full_scale_ua_o, .pd_settle_cycles_o, .led_settle_cycles_o,
      .ch1_offset_ua_o, .ch2_offset_ua_o, .led_driver_a_en_o,
      .led_a_current_code_o);

   // ****************************************
   // access tasks
   // ****************************************
   task automatic step;
      @(posedge core_clk_i);
      #1;
   endtask : step
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      step;
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      step;
      reg_wr_i = 1'b0;
      step;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input logic hit);
      step;
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      step;
      reg_rd_i = 1'b0;
      chk(reg_rdata_o, exp);
      chk(reg_hit_o, {11'h000, hit});
   endtask : rd
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         final_report;
      end
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, exposure_i} = 4'h0;
      {reg_addr_i, reg_wdata_i} = 16'h0000;
      active_slot_i = 3'h0;
      repeat (3) @(posedge core_clk_i);
      #1;
      rst_n_i = 1'b1;
      repeat (4) step;
      rd(SLOT1_CFG1_ADDR, CFG1_RST, 1'b1);
      rd(SLOT1_FILT_ADDR, FILT_RST, 1'b1);
      rd(SLOT1_SETL_ADDR, SETL_RST, 1'b1);
      rd(SLOT1_OFFS_ADDR, 8'h00, 1'b1);
      rd(SLOT1_LEDA_ADDR, 8'h00, 1'b1);
      chk(pd_settle_cycles_o, 12'h0F2);
      chk(led_full_scale_ma_o, 12'h080);
      wr(SLOT1_SETL_ADDR, 8'hFF);
      rd(SLOT1_SETL_ADDR, 8'hF8, 1'b1);
      wr(SLOT1_OFFS_ADDR, 8'hFF);
      rd(SLOT1_OFFS_ADDR, 8'h77, 1'b1);
      wr(8'h27, 8'hFF);
      rd(8'h27, 8'h00, 1'b0);
      wr(SLOT1_CFG1_ADDR, 8'hFF);
      rd(SLOT1_CFG1_ADDR, 8'hDF, 1'b1);
      for (int i = 0; i < 8; i++) begin
         wr(SLOT1_CFG1_ADDR, 8'h18 | 8'(i));
         chk(burst_pulses_o, 12'h001 << i);
         chk(burst_average_code_o, 12'(i));
         chk(center_difference_method_o, 12'h001);
      end
      wr(SLOT1_FILT_ADDR, 8'h7A);
      chk(burst_pulses_o, 12'h001);
      chk(forward_difference_method_o, 12'h001);
      chk(center_difference_method_o, 12'h000);
      wr(SLOT1_FILT_ADDR, 8'hBA);
      chk(cubic_decimation_o, 12'h001);
      wr(SLOT1_CFG1_ADDR, 8'h10);
      chk(cubic_decimation_o, 12'h000);
      chk(integration_time_code_o, 12'h002);
      wr(SLOT1_CFG1_ADDR, 8'h18);
      chk(cubic_decimation_o, 12'h001);
      wr(SLOT1_FILT_ADDR, 8'h3A);
      chk(cubic_decimation_o, 12'h000);
      for (int r = 0; r < 4; r++) begin
         wr(SLOT1_FILT_ADDR, 8'((r << 4) | ((3 - r) << 2) | r));
         chk(led_full_scale_ma_o, 12'(32 * (r + 1)));
         chk(ch1_full_scale_ua_o, 12'h004 << r);
         chk(ch2_full_scale_ua_o, 12'h004 << (3 - r));
         chk(led_current_range_o, 12'(r));
         chk(ch1_adc_range_o, 12'(r));
         chk(ch2_adc_range_o, 12'(3 - r));
      end
      for (int p = 0; p < 8; p++) begin
         wr(SLOT1_SETL_ADDR, 8'((p << 5) | ((p % 4) << 3)));
         chk(pd_settle_cycles_o, pd_tab[p]);
         chk(led_settle_cycles_o, led_tab[p % 4]);
         if (p < 4) begin
            chk(pd_settle_cycles_o - led_settle_cycles_o, 12'h002);
         end
      end
      wr(SLOT1_OFFS_ADDR, 8'h17);
      chk(ch1_offset_ua_o, 12'h000);
      exposure_i = 1'b1;
      step;
      chk(ch1_offset_ua_o, 12'h01C);
      chk(ch2_offset_ua_o, 12'h004);
      exposure_i = 1'b0;
      wr(SLOT1_LEDA_ADDR, 8'hFF);
      chk(led_driver_a_en_o, 12'h001);
      chk(led_a_current_code_o, 12'h0FF);
      wr(SLOT1_LEDA_ADDR, 8'h00);
      chk(led_driver_a_en_o, 12'h000);
      wr(SLOT1_FILT_ADDR + SLOT_STRIDE, 8'h00);
      active_slot_i = 3'h1;
      step;
      chk(led_full_scale_ma_o, 12'h020);
      active_slot_i = 3'h6;
      step;
      chk(led_full_scale_ma_o, 12'h080);
      final_report;
   end
endmodule : tb
